// ---- rtl/nsc_pkg.sv ----
package nsc_pkg;
   // ***************************************************
   // Register map (I/O addresses)
   // ***************************************************
   localparam logic [15:0] STATUS_CONTROL_ADDR = 16'h0061;
   localparam logic [15:0] MASK_INDEX_ADDR     = 16'h0070;
   localparam logic [15:0] EXT_STATUS_ADDR     = 16'h0461;
   localparam logic [15:0] SW_TRIGGER_ADDR     = 16'h0462;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int BOARD_ERR_BIT  = 7;
   localparam int CHAN_CHK_BIT   = 6;
   localparam int SPK_OUT_BIT    = 5;
   localparam int REFRESH_BIT    = 4;
   localparam int CHK_DIS_BIT    = 3;
   localparam int BRD_DIS_BIT    = 2;
   localparam int SPK_EN_BIT     = 1;
   localparam int GATE_BIT       = 0;
   localparam int FAILSAFE_BIT   = 7;
   localparam int TIMEOUT_BIT    = 6;
   localparam int SWNMI_BIT      = 5;
   localparam int SHORT_TO_BIT   = 4;
   localparam int TO_EN_BIT      = 3;
   localparam int FS_EN_BIT      = 2;
   localparam int SW_EN_BIT      = 1;
   localparam int BUS_RST_BIT    = 0;
   localparam int MASK_BIT       = 7;
   localparam int INDEX_W        = 7;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [3:0] CTRL_RST  = 4'h0;
   localparam logic [3:0] ECTRL_RST = 4'h0;
   localparam logic       MASK_RST  = 1'b1;
   localparam logic [6:0] INDEX_RST = 7'h00;

   // Host I/O request carrier
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } nsc_io_req_t;

   // Event inputs from neighbouring logic
   typedef struct packed {
      logic parityPulse;
      logic chanCheck;
      logic spkCntOut;
      logic refreshDone;
      logic failSafeExpire;
      logic timeout64;
      logic timeout256;
   } nsc_events_t;
endpackage

// ---- rtl/nsc_latch.sv ----
`timescale 1ns/1ps
// Sticky source bit: set by event when enabled, cleared while disabled
module nsc_latch (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic setEvt,
   input  wire logic enable,
   output logic      flag
);
   typedef struct packed {
      logic flag;
   } nsc_latch_st_t;
   nsc_latch_st_t s_q;
   nsc_latch_st_t s_d;

   // Disable wins, since a disabled source must read as cleared
   always_comb begin
      s_d = s_q;
      if (!enable) begin
         s_d.flag = 1'b0;
      end else if (setEvt) begin
         s_d.flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign flag = s_q.flag;
endmodule

// ---- rtl/nsc_rdmux.sv ----
`timescale 1ns/1ps
// Read data selection by I/O address
module nsc_rdmux
   import nsc_pkg::*;
(
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  statusByte,
   input  wire logic [7:0]  extByte,
   output logic             hit,
   output logic [7:0]       data
);
   import nsc_pkg::*;

   // Write-only ports do not answer reads
   always_comb begin
      hit  = 1'b0;
      data = 8'h00;
      if (addr == STATUS_CONTROL_ADDR) begin
         hit  = 1'b1;
         data = statusByte;
      end else if (addr == EXT_STATUS_ADDR) begin
         hit  = 1'b1;
         data = extByte;
      end
   end
endmodule

// ---- rtl/nmi_source_control.sv ----
`timescale 1ns/1ps
module nmi_source_control
   import nsc_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  nsc_pkg::nsc_io_req_t ioReq,
   input  nsc_pkg::nsc_events_t evt,
   input  wire logic         normalResetDrive,
   output logic [7:0]        rdata,
   output logic              rvalid,
   output logic              nmiOut,
   output logic              speaker_out,
   output logic              spkGate,
   output logic              busResetOut,
   output logic [6:0]        clockIndex
);
   import nsc_pkg::*;

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [3:0] ctrl;
      logic [3:0] ectrl;
      logic       mask;
      logic [6:0] index;
      logic       refreshTgl;
      logic       shortTo;
      logic [7:0] rdata;
      logic       rvalid;
      logic       nmi;
      logic       spk;
      logic       gate;
      logic       busRst;
   } nsc_state_t;

   nsc_state_t s_q;
   nsc_state_t s_d;

   logic boardErr;
   logic chanChk;
   logic failSafe;
   logic busTo;
   logic swNmi;
   logic rdHit;
   logic [7:0] rdByte;
   logic [7:0] statusByte;
   logic [7:0] extByte;
   logic wrTrig;
   logic anyTo;

   assign wrTrig = ioReq.wr && (ioReq.addr == SW_TRIGGER_ADDR);
   assign anyTo  = evt.timeout64 || evt.timeout256;

   // ***************************************************
   // Source latches
   // ***************************************************
   // Enables are the written control bits (active-low for the first two)
   nsc_latch u_board (
      .core_clk (core_clk),
      .rst      (rst),
      .setEvt   (evt.parityPulse),
      .enable   (!s_q.ctrl[BRD_DIS_BIT]),
      .flag     (boardErr)
   );
   nsc_latch u_chk (
      .core_clk (core_clk),
      .rst      (rst),
      .setEvt   (evt.chanCheck),
      .enable   (!s_q.ctrl[CHK_DIS_BIT]),
      .flag     (chanChk)
   );
   nsc_latch u_fs (
      .core_clk (core_clk),
      .rst      (rst),
      .setEvt   (evt.failSafeExpire),
      .enable   (s_q.ectrl[FS_EN_BIT]),
      .flag     (failSafe)
   );
   nsc_latch u_to (
      .core_clk (core_clk),
      .rst      (rst),
      .setEvt   (anyTo),
      .enable   (s_q.ectrl[TO_EN_BIT]),
      .flag     (busTo)
   );
   nsc_latch u_sw (
      .core_clk (core_clk),
      .rst      (rst),
      .setEvt   (wrTrig),
      .enable   (s_q.ectrl[SW_EN_BIT]),
      .flag     (swNmi)
   );

   // ***************************************************
   // Read view
   // ***************************************************
   // Speaker counter level is passed live, so it may be unknown
   // until the counter is programmed
   assign statusByte = {boardErr, chanChk, evt.spkCntOut,
                        s_q.refreshTgl, s_q.ctrl};
   assign extByte    = {failSafe, busTo, swNmi, s_q.shortTo,
                        s_q.ectrl};

   nsc_rdmux u_rd (
      .addr       (ioReq.addr),
      .statusByte (statusByte),
      .extByte    (extByte),
      .hit        (rdHit),
      .data       (rdByte)
   );

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      s_d = s_q;
      // Write decode; upper nibbles are ignored on writes to the two status/control ports
      if (ioReq.wr) begin
         unique case (ioReq.addr)
            STATUS_CONTROL_ADDR: begin
               s_d.ctrl = ioReq.wdata[3:0];
            end
            EXT_STATUS_ADDR: begin
               s_d.ectrl = ioReq.wdata[3:0];
            end
            MASK_INDEX_ADDR: begin
               s_d.mask  = ioReq.wdata[MASK_BIT];
               s_d.index = ioReq.wdata[INDEX_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Refresh flips the toggle bit
      if (evt.refreshDone) begin
         s_d.refreshTgl = !s_q.refreshTgl;
      end
      // Short-timeout tag follows the latest timeout seen
      if (!s_q.ectrl[TO_EN_BIT]) begin
         s_d.shortTo = 1'b0;
      end else if (anyTo) begin
         s_d.shortTo = evt.timeout64;
      end
      s_d.rvalid = ioReq.rd && rdHit;
      s_d.rdata  = (ioReq.rd && rdHit) ? rdByte : 8'h00;
      // Outputs registered; one cycle behind their causes
      s_d.nmi    = !s_q.mask && (boardErr || chanChk || failSafe ||
                                 busTo || swNmi);
      s_d.spk    = s_q.ctrl[SPK_EN_BIT] && evt.spkCntOut;
      s_d.gate   = s_q.ctrl[GATE_BIT];
      s_d.busRst = s_q.ectrl[BUS_RST_BIT] || normalResetDrive;
   end

   // Mask comes up set so no NMI escapes before software is ready
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q        <= '0;
         s_q.ctrl   <= CTRL_RST;
         s_q.ectrl  <= ECTRL_RST;
         s_q.mask   <= MASK_RST;
         s_q.index  <= INDEX_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata       = s_q.rdata;
   assign rvalid      = s_q.rvalid;
   assign nmiOut      = s_q.nmi;
   assign speaker_out = s_q.spk;
   assign spkGate     = s_q.gate;
   assign busResetOut = s_q.busRst;
   assign clockIndex  = s_q.index;

   // ***************************************************
   // Assertions
   // ***************************************************
   property p_mask_blocks;
      @(posedge core_clk) disable iff (rst)
         s_q.mask && $past(s_q.mask) |-> !nmiOut;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks)
      else $error("NMI while masked");

   property p_nmi_source;
      @(posedge core_clk) disable iff (rst)
         (!s_q.mask && chanChk) |=> nmiOut;
   endproperty
   a_nmi_source: assert property (p_nmi_source)
      else $error("NMI missing for latched source");

   property p_chk_set;
      @(posedge core_clk) disable iff (rst)
         evt.chanCheck && !s_q.ctrl[CHK_DIS_BIT] |=> chanChk;
   endproperty
   a_chk_set: assert property (p_chk_set)
      else $error("Channel check not latched");

   property p_chk_clr;
      @(posedge core_clk) disable iff (rst)
         s_q.ctrl[CHK_DIS_BIT] |=> !chanChk;
   endproperty
   a_chk_clr: assert property (p_chk_clr)
      else $error("Channel check not cleared");

   property p_brd_set;
      @(posedge core_clk) disable iff (rst)
         evt.parityPulse && !s_q.ctrl[BRD_DIS_BIT] |=> boardErr;
   endproperty
   a_brd_set: assert property (p_brd_set)
      else $error("Board error not latched");

   property p_refresh;
      @(posedge core_clk) disable iff (rst)
         evt.refreshDone |=> s_q.refreshTgl != $past(s_q.refreshTgl);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("Refresh toggle stuck");

   property p_spk;
      @(posedge core_clk) disable iff (rst)
         !s_q.ctrl[SPK_EN_BIT] |=> !speaker_out;
   endproperty
   a_spk: assert property (p_spk)
      else $error("Speaker on while disabled");

   property p_sw;
      @(posedge core_clk) disable iff (rst)
         wrTrig && s_q.ectrl[SW_EN_BIT] |=> swNmi;
   endproperty
   a_sw: assert property (p_sw)
      else $error("Software NMI not set");

   property p_fs_clr;
      @(posedge core_clk) disable iff (rst)
         !s_q.ectrl[FS_EN_BIT] |=> !failSafe;
   endproperty
   a_fs_clr: assert property (p_fs_clr)
      else $error("Fail-safe not cleared");

   property p_busrst;
      @(posedge core_clk) disable iff (rst)
         s_q.ectrl[BUS_RST_BIT] |=> busResetOut;
   endproperty
   a_busrst: assert property (p_busrst)
      else $error("Bus reset not driven");

   property p_brd_clr;
      @(posedge core_clk) disable iff (rst)
         s_q.ctrl[BRD_DIS_BIT] |=> !boardErr;
   endproperty
   a_brd_clr: assert property (p_brd_clr)
      else $error("Board error not cleared");

   property p_fs_set;
      @(posedge core_clk) disable iff (rst)
         evt.failSafeExpire && s_q.ectrl[FS_EN_BIT] |=> failSafe;
   endproperty
   a_fs_set: assert property (p_fs_set)
      else $error("Fail-safe expiry not latched");

   property p_to_set;
      @(posedge core_clk) disable iff (rst)
         anyTo && s_q.ectrl[TO_EN_BIT] |=> busTo;
   endproperty
   a_to_set: assert property (p_to_set)
      else $error("Bus timeout not latched");

   // Tag must name the length of the timeout just seen
   property p_short;
      @(posedge core_clk) disable iff (rst)
         anyTo && s_q.ectrl[TO_EN_BIT]
            |=> s_q.shortTo == $past(evt.timeout64);
   endproperty
   a_short: assert property (p_short)
      else $error("Short timeout tag wrong");

   property p_to_clr;
      @(posedge core_clk) disable iff (rst)
         !s_q.ectrl[TO_EN_BIT] |=> !busTo && !s_q.shortTo;
   endproperty
   a_to_clr: assert property (p_to_clr)
      else $error("Bus timeout not cleared");

   c_nmi: cover property (@(posedge core_clk) disable iff (rst)
      $rose(nmiOut));
   c_sw: cover property (@(posedge core_clk) disable iff (rst)
      $rose(swNmi));
   c_short: cover property (@(posedge core_clk) disable iff (rst)
      busTo && s_q.shortTo);
   c_busrst: cover property (@(posedge core_clk) disable iff (rst)
      $rose(busResetOut));
endmodule

// ---- testbench/nsc_host_model.sv ----
`timescale 1ns/1ps
// Host side: issues single-cycle I/O strobes on the falling edge
module nsc_host_model
   import nsc_pkg::*;
(
   input  wire logic            core_clk,
   input  wire logic            rvalid,
   input  wire logic [7:0]      rdata,
   output nsc_pkg::nsc_io_req_t ioReq
);
   import nsc_pkg::*;

   // Idle bus at time zero
   initial begin
      ioReq = '0;
   end

   // Write; read-only nibbles are zeroed unless raw is set
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit raw);
      @(negedge core_clk);
      ioReq.addr  = a;
      ioReq.wdata = d;
      if (!raw && (a == STATUS_CONTROL_ADDR || a == EXT_STATUS_ADDR)) begin
         ioReq.wdata = {4'h0, d[3:0]};
      end
      ioReq.wr = 1'b1;
      @(negedge core_clk);
      // Released lines show the inverse so stale values cannot match
      ioReq.wr    = 1'b0;
      ioReq.addr  = ~a;
      ioReq.wdata = ~d;
   endtask

   // Read; the answer is awaited for three falling edges at most
   task automatic rd(input logic [15:0] a, output logic [7:0] d,
                     output bit ok);
      ok = 1'b0;
      d  = 8'h00;
      @(negedge core_clk);
      ioReq.addr = a;
      ioReq.rd   = 1'b1;
      @(negedge core_clk);
      ioReq.rd   = 1'b0;
      ioReq.addr = ~a;
      for (int i = 0; i < 3 && !ok; i++) begin
         if (rvalid === 1'b1) begin
            ok = 1'b1;
            d  = rdata;
         end else begin
            @(negedge core_clk);
         end
      end
   endtask
endmodule

// ---- testbench/nmi_source_control_tb_top.sv ----
`timescale 1ns/1ps
module nmi_source_control_tb_top;
   import nsc_pkg::*;
   // ***************************************************
   // Signals and reference model state
   // ***************************************************
   logic        core_clk, rst, normalResetDrive, spk;
   logic        rvalid, nmiOut, speaker_out, spkGate, busResetOut;
   logic [7:0]  rdata, rnd, d;
   logic [6:0]  clockIndex, idx;
   logic [5:0]  pulses;
   logic [3:0]  ctl, ectl;
   logic        brd, chk, tgl, fs, to, sw, sh, msk;
   nsc_io_req_t ioReq;
   nsc_events_t evt;
   int          fails, checks;
   bit          ok;

   // Event strobes one-hot; speaker counter level from the bench
   assign evt = {pulses[5:4], spk, pulses[0], pulses[3:1]};

   nsc_host_model host (.core_clk(core_clk), .rvalid(rvalid),
                        .rdata(rdata), .ioReq(ioReq));

   nmi_source_control dut_u (.core_clk(core_clk), .rst(rst), .ioReq(ioReq),
      .evt(evt), .normalResetDrive(normalResetDrive), .rdata(rdata),
      .rvalid(rvalid), .nmiOut(nmiOut), .speaker_out(speaker_out),
      .spkGate(spkGate), .busResetOut(busResetOut), .clockIndex(clockIndex));

   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task finish_test;
      if (fails == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Read and compare; a missing answer ends the run
   task rdchk(input logic [15:0] a, input logic [7:0] exp, input bit hit);
      host.rd(a, d, ok);
      checks++;
      if (ok != hit) begin
         fails++;
         $display("[ERR] %0t read %h answer %0b", $time, a, ok);
      end
      if (hit && !ok) begin
         finish_test();
      end else if (hit) begin
         cmp(d, exp);
      end
   endtask

   // Write and mirror it in the model
   task w(input logic [15:0] a, input logic [7:0] v, input bit raw);
      host.wr(a, v, raw);
      case (a)
         STATUS_CONTROL_ADDR: begin
            ctl = v[3:0];
            brd &= ~v[2];
            chk &= ~v[3];
         end
         MASK_INDEX_ADDR: {msk, idx} = v;
         EXT_STATUS_ADDR: begin
            ectl = v[3:0];
            fs &= v[2];
            to &= v[3];
            sh &= v[3];
            sw &= v[1];
         end
         default: sw |= ectl[1];
      endcase
   endtask

   // One-cycle event: 0 parity,1 check,2 failsafe,3 t64,4 t256,5 refresh
   task pulse(input int k);
      @(negedge core_clk);
      pulses = 6'h20 >> k;
      @(negedge core_clk);
      pulses = 6'h00;
      case (k)
         0: brd |= ~ctl[2];
         1: chk |= ~ctl[3];
         2: fs |= ectl[2];
         3, 4: begin
            if (ectl[3]) sh = (k == 3);
            to |= ectl[3];
         end
         default: tgl = ~tgl;
      endcase
   endtask

   // Random speaker level, let outputs settle, then compare everything
   task chk_all;
      rnd = lfsr(rnd);
      @(negedge core_clk);
      spk = rnd[0];
      repeat (3) @(negedge core_clk);
      rdchk(STATUS_CONTROL_ADDR, {brd, chk, spk, tgl, ctl}, 1);
      rdchk(EXT_STATUS_ADDR, {fs, to, sw, sh, ectl}, 1);
      cmp({4'h0, nmiOut, speaker_out, spkGate, busResetOut}, {4'h0,
          ~msk & (brd | chk | fs | to | sw), ctl[1] & spk, ctl[0],
          ectl[0] | normalResetDrive});
      cmp({1'b0, clockIndex}, {1'b0, idx});
   endtask

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      {rst, normalResetDrive, spk, pulses, rnd} = {3'b100, 6'h00, 8'h2e};
      {ctl, ectl, brd, chk, tgl, fs, to, sw, sh, msk, idx} = '0;
      msk = 1'b1;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      chk_all();
      w(STATUS_CONTROL_ADDR, 8'hf3, 1);
      chk_all();
      w(MASK_INDEX_ADDR, 8'h05, 0);
      pulse(0);
      chk_all();
      pulse(1);
      pulse(5);
      chk_all();
      w(MASK_INDEX_ADDR, 8'h85, 0);
      chk_all();
      w(STATUS_CONTROL_ADDR, 8'h0c, 0);
      pulse(0);
      pulse(1);
      chk_all();
      w(STATUS_CONTROL_ADDR, 8'h00, 0);
      w(MASK_INDEX_ADDR, 8'h2a, 0);
      w(EXT_STATUS_ADDR, 8'hfe, 1);
      pulse(2);
      pulse(3);
      chk_all();
      pulse(4);
      w(SW_TRIGGER_ADDR, rnd, 0);
      chk_all();
      w(EXT_STATUS_ADDR, 8'h00, 0);
      pulse(2);
      pulse(3);
      w(SW_TRIGGER_ADDR, ~rnd, 0);
      chk_all();
      w(EXT_STATUS_ADDR, 8'h01, 0);
      repeat (9) @(negedge core_clk);
      chk_all();
      w(EXT_STATUS_ADDR, 8'h00, 0);
      normalResetDrive = 1'b1;
      chk_all();
      normalResetDrive = 1'b0;
      // Long timeout alone must still latch, with the short tag clear
      w(EXT_STATUS_ADDR, 8'h08, 0);
      pulse(4);
      chk_all();
      rdchk(MASK_INDEX_ADDR, 8'h00, 0);
      rdchk(SW_TRIGGER_ADDR, 8'h00, 0);
      rdchk(16'h0123, 8'h00, 0);
      finish_test();
   end
endmodule
